// file: home_return_pkg.sv
// Constants for the home return sequencer: register map, field layout,
// homing type codes, reset values and sequencer states.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package home_return_pkg;

	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [5:0] OFS_TYPE_DIR  = 6'h00;
	localparam logic [5:0] OFS_SEARCH    = 6'h04;
	localparam logic [5:0] OFS_CREEP     = 6'h08;
	localparam logic [5:0] OFS_SHIFT     = 6'h0c;
	localparam logic [5:0] OFS_PRESET    = 6'h10;
	localparam logic [5:0] OFS_POLARITY  = 6'h14;
	localparam logic [5:0] OFS_AFTER_DOG = 6'h18;
	localparam logic [5:0] OFS_STATUS    = 6'h1c;
	localparam logic [5:0] OFS_CUR_POS   = 6'h20;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int TYPE_LSB    = 0;
	localparam int TYPE_W      = 4;
	localparam int DIR_BIT     = 4;
	localparam int POL_BIT     = 0;
	localparam int ST_DONE_BIT = 0;
	localparam int ST_BUSY_BIT = 1;
	localparam int SPEED_W     = 16;

	// ------------------------------------------------------------------
	// Homing type codes
	// ------------------------------------------------------------------
	localparam logic [3:0] TYPE_DOG       = 4'h0;
	localparam logic [3:0] TYPE_REAR_END  = 4'h1;
	localparam logic [3:0] TYPE_COUNT_FE  = 4'h2;
	localparam logic [3:0] TYPE_CRADLE    = 4'h3;
	localparam logic [3:0] TYPE_LAST_Z    = 4'h4;
	localparam logic [3:0] TYPE_DOG_FE    = 4'h5;
	localparam logic [3:0] TYPE_DOGLESS_Z = 4'h6;

	// ------------------------------------------------------------------
	// Reset values and fixed selections
	// ------------------------------------------------------------------
	localparam logic [31:0] RST_TYPE_DIR  = 32'h0000_0000;
	localparam logic [15:0] RST_SEARCH    = 16'h0064;
	localparam logic [15:0] RST_CREEP     = 16'h000a;
	localparam logic [31:0] RST_DISTANCE  = 32'h0000_0000;
	localparam logic        RST_POLARITY  = 1'b1;
	localparam logic [4:0]  HOMING_ENTRY  = 5'h01;
	localparam logic [4:0]  NO_ENTRY      = 5'h00;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SEARCH = 3'b001,
		ST_CREEP  = 3'b010,
		ST_WAIT_Z = 3'b011,
		ST_SHIFT  = 3'b100
	} state_t;

endpackage

// file: home_return_sequencer.sv
// Home return sequencer for one servo axis, with its Avalon-MM register slave.
// Assumes dog_i, index_i and feedback_pos_i are synchronous to core_clk_i and
// that a downstream profile generator follows the speed, direction and entry.
//
// How it works
// RULE1 - Dog type: index after dog rear, plus shift
// RULE2 - Rear-end type: after-dog travel plus shift, no index
// RULE3 - Count front-end: decelerate at front, travel plus shift
// RULE4 - Cradle: first index after dog front end
// RULE5 - Last-index: reverse at dog front, index plus shift
// RULE6 - Dog front-end: travel plus shift from front end
// RULE7 - Dogless: first index plus shift, dog ignored
// RULE8 - Direction 0 increasing, 1 decreasing addresses
// RULE9 - Polarity 0 detects dog off, 1 on
// RULE10 - Host requests with mode select, table selects off
// RULE11 - Type code 0 selects basic dog method
// RULE12 - Search speed until dog, then creep speed
// RULE13 - Homing uses point table entry 1 ramps
// RULE14 - Completion loads current position with preset
// RULE15 - Done flag set on preset, cleared on start
`timescale 1ns/1ps

module home_return_sequencer (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// Avalon-MM slave
	input  wire logic [5:0]  address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [31:0] writedata_i,
	input  wire logic [3:0]  byteenable_i,
	output logic      [31:0] readdata_o,
	output logic             waitrequest_o,
	// Mode selection from the host
	input  wire logic        op_mode_select_1_i,
	input  wire logic [4:0]  table_index_select_i,
	// Switch and encoder
	input  wire logic        dog_i,
	input  wire logic        index_i,
	input  wire logic [31:0] feedback_pos_i,
	// Motion command
	output logic      [15:0] cmd_speed_o,
	output logic             cmd_dir_o,
	output logic             cmd_run_o,
	output logic             decel_o,
	output logic      [4:0]  accel_entry_o,
	// Status
	output logic      [31:0] cur_pos_o,
	output logic             home_done_o
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------------
	// Register slave
	// ------------------------------------------------------------------
	logic [31:0] type_dir_q, type_dir_d;
	logic [15:0] search_q, search_d;
	logic [15:0] creep_q, creep_d;
	logic [31:0] shift_q, shift_d;
	logic [31:0] preset_q, preset_d;
	logic        pol_q, pol_d;
	logic [31:0] after_q, after_d;
	logic        ack_q, ack_d;
	logic        wait_q;
	logic [31:0] rdata_q, rdata_d;

	home_return_pkg::state_t state_q, state_d;
	logic        done_q, done_d;
	logic [31:0] cur_pos_q, cur_pos_d;

	// The answer comes one edge after the request so read data are registered.
	always_comb begin
		type_dir_d = type_dir_q;
		search_d   = search_q;
		creep_d    = creep_q;
		shift_d    = shift_q;
		preset_d   = preset_q;
		pol_d      = pol_q;
		after_d    = after_q;
		ack_d      = (read_i || write_i) && !ack_q;
		rdata_d    = rdata_q;
		if (ack_d && write_i) begin
			unique case (address_i)
				home_return_pkg::OFS_TYPE_DIR:  type_dir_d = merge(type_dir_q, writedata_i,
					byteenable_i);
				home_return_pkg::OFS_SEARCH:    search_d = 16'(merge({16'h0000, search_q},
					writedata_i, byteenable_i));
				home_return_pkg::OFS_CREEP:     creep_d = 16'(merge({16'h0000, creep_q},
					writedata_i, byteenable_i));
				home_return_pkg::OFS_SHIFT:     shift_d = merge(shift_q, writedata_i, byteenable_i);
				home_return_pkg::OFS_PRESET:    preset_d = merge(preset_q, writedata_i, byteenable_i);
				home_return_pkg::OFS_POLARITY: begin
					if (byteenable_i[0]) begin
						pol_d = writedata_i[home_return_pkg::POL_BIT];
					end
				end
				home_return_pkg::OFS_AFTER_DOG: after_d = merge(after_q, writedata_i, byteenable_i);
				default: ;
			endcase
		end
		if (ack_d && read_i) begin
			unique case (address_i)
				home_return_pkg::OFS_TYPE_DIR:  rdata_d = type_dir_q;
				home_return_pkg::OFS_SEARCH:    rdata_d = {16'h0000, search_q};
				home_return_pkg::OFS_CREEP:     rdata_d = {16'h0000, creep_q};
				home_return_pkg::OFS_SHIFT:     rdata_d = shift_q;
				home_return_pkg::OFS_PRESET:    rdata_d = preset_q;
				home_return_pkg::OFS_POLARITY:  rdata_d = {31'h0000_0000, pol_q};
				home_return_pkg::OFS_AFTER_DOG: rdata_d = after_q;
				home_return_pkg::OFS_STATUS:    rdata_d = {27'h000_0000, state_q,
					(state_q != home_return_pkg::ST_IDLE), done_q};
				home_return_pkg::OFS_CUR_POS:   rdata_d = cur_pos_q;
				default:                        rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			type_dir_q <= home_return_pkg::RST_TYPE_DIR;
			search_q   <= home_return_pkg::RST_SEARCH;
			creep_q    <= home_return_pkg::RST_CREEP;
			shift_q    <= home_return_pkg::RST_DISTANCE;
			preset_q   <= home_return_pkg::RST_DISTANCE;
			pol_q      <= home_return_pkg::RST_POLARITY;
			after_q    <= home_return_pkg::RST_DISTANCE;
			ack_q      <= 1'b0;
			wait_q     <= 1'b1;
			rdata_q    <= 32'h0000_0000;
		end else begin
			type_dir_q <= type_dir_d;
			search_q   <= search_d;
			creep_q    <= creep_d;
			shift_q    <= shift_d;
			preset_q   <= preset_d;
			pol_q      <= pol_d;
			after_q    <= after_d;
			ack_q      <= ack_d;
			wait_q     <= !ack_d;
			rdata_q    <= rdata_d;
		end
	end

	assign readdata_o    = rdata_q;
	assign waitrequest_o = wait_q;

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	logic [3:0]  htype;
	logic        req, start, det, lead, trail, moved_ok;
	logic [31:0] moved;
	logic        req_q, req_d, det_q, det_d, dir_q, dir_d, decel_q, decel_d, run_q, run_d;
	logic [15:0] speed_q, speed_d;
	logic [31:0] origin_q, origin_d, target_q, target_d, fb_q, fb_d;
	logic [3:0]  run_type_q, run_type_d;

	assign htype    = type_dir_q[home_return_pkg::TYPE_LSB +: home_return_pkg::TYPE_W];
	assign req      = op_mode_select_1_i && (table_index_select_i == 5'h00); // RULE10
	assign start    = req && !req_q;
	assign det      = pol_q ? dog_i : !dog_i; // RULE9
	assign lead     = det && !det_q;
	assign trail    = !det && det_q;
	assign moved    = dir_q ? (origin_q - feedback_pos_i) : (feedback_pos_i - origin_q);
	assign moved_ok = (moved >= target_q);

	always_comb begin
		state_d    = state_q;
		req_d      = req;
		det_d      = det;
		dir_d      = dir_q;
		decel_d    = decel_q;
		run_d      = run_q;
		speed_d    = speed_q;
		origin_d   = origin_q;
		target_d   = target_q;
		run_type_d = run_type_q;
		done_d     = done_q;
		fb_d       = feedback_pos_i;
		// Position follows the encoder between homings; the preset overrides it.
		cur_pos_d  = cur_pos_q + (feedback_pos_i - fb_q);
		unique case (state_q)
			home_return_pkg::ST_IDLE: begin
				if (start && htype <= home_return_pkg::TYPE_DOGLESS_Z) begin
					done_d     = 1'b0; // RULE15
					run_type_d = htype;
					dir_d      = type_dir_q[home_return_pkg::DIR_BIT]; // RULE8
					run_d      = 1'b1;
					decel_d    = 1'b0;
					if (htype == home_return_pkg::TYPE_DOGLESS_Z) begin
						speed_d = creep_q;
						state_d = home_return_pkg::ST_WAIT_Z; // RULE7
					end else begin
						speed_d = search_q; // RULE12
						state_d = home_return_pkg::ST_SEARCH; // RULE11
					end
				end
			end
			home_return_pkg::ST_SEARCH: begin
				if (lead) begin
					speed_d  = creep_q; // RULE12
					decel_d  = 1'b1;
					origin_d = feedback_pos_i;
					target_d = 32'(after_q + shift_q);
					unique case (run_type_q)
						home_return_pkg::TYPE_COUNT_FE,
						home_return_pkg::TYPE_DOG_FE: state_d = home_return_pkg::ST_SHIFT; // RULE3 RULE6
						home_return_pkg::TYPE_CRADLE: state_d = home_return_pkg::ST_WAIT_Z; // RULE4
						home_return_pkg::TYPE_LAST_Z: begin
							dir_d   = !dir_q; // RULE5
							state_d = home_return_pkg::ST_WAIT_Z;
						end
						default: state_d = home_return_pkg::ST_CREEP; // RULE1
					endcase
				end
			end
			home_return_pkg::ST_CREEP: begin
				// Both dog and rear-end types wait here for the dog rear end.
				if (trail) begin
					origin_d = feedback_pos_i;
					if (run_type_q == home_return_pkg::TYPE_REAR_END) begin
						target_d = 32'(after_q + shift_q);
						state_d  = home_return_pkg::ST_SHIFT; // RULE2
					end else begin
						state_d  = home_return_pkg::ST_WAIT_Z; // RULE1
					end
				end
			end
			home_return_pkg::ST_WAIT_Z: begin
				if (index_i) begin
					origin_d = feedback_pos_i;
					target_d = (run_type_q == home_return_pkg::TYPE_CRADLE) ? 32'h0000_0000
						: shift_q; // RULE1 RULE4 RULE5 RULE7
					state_d  = home_return_pkg::ST_SHIFT;
				end
			end
			home_return_pkg::ST_SHIFT: begin
				if (moved_ok) begin
					cur_pos_d = preset_q; // RULE14
					done_d    = 1'b1; // RULE15
					run_d     = 1'b0;
					decel_d   = 1'b0;
					speed_d   = 16'h0000;
					state_d   = home_return_pkg::ST_IDLE;
				end
			end
			default: state_d = home_return_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_q    <= home_return_pkg::ST_IDLE;
			req_q      <= 1'b0;
			det_q      <= 1'b0;
			dir_q      <= 1'b0;
			decel_q    <= 1'b0;
			run_q      <= 1'b0;
			speed_q    <= 16'h0000;
			origin_q   <= 32'h0000_0000;
			target_q   <= 32'h0000_0000;
			run_type_q <= home_return_pkg::TYPE_DOG;
			done_q     <= 1'b0;
			fb_q       <= 32'h0000_0000;
			cur_pos_q  <= 32'h0000_0000;
		end else begin
			state_q    <= state_d;
			req_q      <= req_d;
			det_q      <= det_d;
			dir_q      <= dir_d;
			decel_q    <= decel_d;
			run_q      <= run_d;
			speed_q    <= speed_d;
			origin_q   <= origin_d;
			target_q   <= target_d;
			run_type_q <= run_type_d;
			done_q     <= done_d;
			fb_q       <= fb_d;
			cur_pos_q  <= cur_pos_d;
		end
	end

	assign cmd_speed_o   = speed_q;
	assign cmd_dir_o     = dir_q;
	assign cmd_run_o     = run_q;
	assign decel_o       = decel_q;
	assign cur_pos_o     = cur_pos_q;
	assign home_done_o   = done_q;

	// Ramp entry follows the run flag so it is a flop output too.
	logic [4:0] entry_q;
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			entry_q <= home_return_pkg::NO_ENTRY;
		end else begin
			entry_q <= run_d ? home_return_pkg::HOMING_ENTRY : home_return_pkg::NO_ENTRY; // RULE13
		end
	end
	assign accel_entry_o = entry_q;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	property p_dog_to_creep;
		@(posedge core_clk_i) disable iff (rst_i)
		(state_q == home_return_pkg::ST_SEARCH && lead && run_type_q == home_return_pkg::TYPE_DOG)
		|=> state_q == home_return_pkg::ST_CREEP && speed_q == creep_q && decel_q;
	endproperty
	a_dog_to_creep: assert property (p_dog_to_creep) else $error("dog front end not handled"); // RULE1

	property p_rear_no_index;
		@(posedge core_clk_i) disable iff (rst_i)
		(state_q == home_return_pkg::ST_CREEP && trail && run_type_q == home_return_pkg::TYPE_REAR_END)
		|=> state_q == home_return_pkg::ST_SHIFT && target_q == after_q + shift_q;
	endproperty
	a_rear_no_index: assert property (p_rear_no_index) else $error("rear end shift wrong"); // RULE2

	property p_cradle_index;
		@(posedge core_clk_i) disable iff (rst_i)
		(state_q == home_return_pkg::ST_WAIT_Z && index_i && run_type_q == home_return_pkg::TYPE_CRADLE)
		|=> state_q == home_return_pkg::ST_SHIFT && target_q == 32'h0000_0000;
	endproperty
	a_cradle_index: assert property (p_cradle_index) else $error("cradle index not taken"); // RULE4

	property p_last_z_reverse;
		@(posedge core_clk_i) disable iff (rst_i)
		(state_q == home_return_pkg::ST_SEARCH && lead && run_type_q == home_return_pkg::TYPE_LAST_Z)
		|=> dir_q != $past(dir_q) ##0 state_q == home_return_pkg::ST_WAIT_Z;
	endproperty
	a_last_z_reverse: assert property (p_last_z_reverse) else $error("no reversal at dog"); // RULE5

	property p_start_dir;
		@(posedge core_clk_i) disable iff (rst_i)
		(state_q == home_return_pkg::ST_IDLE && start && htype <= home_return_pkg::TYPE_DOGLESS_Z)
		|=> cmd_dir_o == $past(type_dir_q[home_return_pkg::DIR_BIT]) && !home_done_o;
	endproperty
	a_start_dir: assert property (p_start_dir) else $error("start direction or done wrong"); // RULE8

	property p_polarity;
		@(posedge core_clk_i) disable iff (rst_i)
		(state_q == home_return_pkg::ST_SEARCH && (dog_i == pol_q) && !det_q)
		|=> state_q != home_return_pkg::ST_SEARCH;
	endproperty
	a_polarity: assert property (p_polarity) else $error("dog polarity ignored"); // RULE9

	property p_search_speed;
		@(posedge core_clk_i) disable iff (rst_i)
		$rose(state_q == home_return_pkg::ST_SEARCH) |-> cmd_speed_o == search_q && !decel_o;
	endproperty
	a_search_speed: assert property (p_search_speed) else $error("search speed not used"); // RULE12

	property p_entry;
		@(posedge core_clk_i) disable iff (rst_i)
		cmd_run_o |-> accel_entry_o == home_return_pkg::HOMING_ENTRY;
	endproperty
	a_entry: assert property (p_entry) else $error("wrong ramp entry while homing"); // RULE13

	property p_preset;
		@(posedge core_clk_i) disable iff (rst_i)
		(state_q == home_return_pkg::ST_SHIFT && moved_ok)
		|=> cur_pos_o == $past(preset_q) && home_done_o && !cmd_run_o;
	endproperty
	a_preset: assert property (p_preset) else $error("preset not loaded at completion"); // RULE14

endmodule

// file: dog_index_model.sv
// Behavioural model of the axis: a proximity dog and an encoder index track.
// Assumes the axis moves one pulse per clock while the sequencer runs at nonzero speed.
`timescale 1ns/1ps

module dog_index_model #(
	parameter int DOG_LO = 40,
	parameter int DOG_HI = 60
) (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// Motion command from the sequencer
	input  wire logic        cmd_run_i,
	input  wire logic        cmd_dir_i,
	input  wire logic [15:0] cmd_speed_i,
	// Bench control
	input  wire logic        load_i,
	input  wire logic [31:0] load_pos_i,
	input  wire logic        active_high_i,
	// Switch and encoder
	output logic             dog_o,
	output logic             index_o,
	output logic      [31:0] pos_o
);
	logic [31:0] pos_q;
	logic [31:0] pos_d;
	logic        moving;
	logic        in_dog;

	always_comb begin
		moving = cmd_run_i && (cmd_speed_i != 16'h0000);
		pos_d  = pos_q;
		if (load_i) begin
			pos_d = load_pos_i;
		end else if (moving) begin
			pos_d = cmd_dir_i ? pos_q - 32'h0000_0001 : pos_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge core_clk_i) begin
		pos_q <= rst_i ? 32'h0000_0002 : pos_d;
	end

	// The index only pulses while the shaft turns, so a stopped axis never repeats it.
	always_comb begin
		in_dog  = (pos_q >= 32'(DOG_LO)) && (pos_q < 32'(DOG_HI));
		dog_o   = active_high_i ? in_dog : !in_dog;
		index_o = moving && (pos_q[3:0] == 4'h0);
		pos_o   = pos_q;
	end
endmodule

// file: home_return_sequencer_bench.sv
// Self-checking bench for the home return sequencer.
// Assumes the axis model above; dog spans 40..59, index every 16 pulses.
`timescale 1ns/1ps

module home_return_sequencer_bench;
	logic        core_clk_i = 1'b0;
	logic        rst_i      = 1'b1;
	logic [5:0]  address_i  = 6'h00;
	logic        read_i     = 1'b0;
	logic        write_i    = 1'b0;
	logic [31:0] writedata_i = 32'h0000_0000;
	logic [3:0]  byteenable_i = 4'hf;
	logic [31:0] readdata_o;
	logic        waitrequest_o;
	logic        op_mode_select_1_i = 1'b0;
	logic [4:0]  table_index_select_i = 5'h00;
	logic        dog_i;
	logic        index_i;
	logic [31:0] feedback_pos_i;
	logic [15:0] cmd_speed_o;
	logic        cmd_dir_o;
	logic        cmd_run_o;
	logic        decel_o;
	logic [4:0]  accel_entry_o;
	logic [31:0] cur_pos_o;
	logic        home_done_o;
	logic        load = 1'b0;
	logic [31:0] load_pos = 32'h0000_0002;
	logic        pol_hi = 1'b1;
	int          n_mismatch = 0;
	int          check_count = 0;
	logic [31:0] rd;
	localparam logic [31:0] PRESET = 32'h0000_1234;
	localparam logic [15:0] SEARCH = 16'h0200;
	localparam logic [15:0] CREEP  = 16'h0020;

	always #5 core_clk_i = ~core_clk_i;

	home_return_sequencer dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .address_i(address_i),
		.read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
		.byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
		.op_mode_select_1_i(op_mode_select_1_i), .table_index_select_i(table_index_select_i),
		.dog_i(dog_i), .index_i(index_i), .feedback_pos_i(feedback_pos_i),
		.cmd_speed_o(cmd_speed_o), .cmd_dir_o(cmd_dir_o), .cmd_run_o(cmd_run_o),
		.decel_o(decel_o), .accel_entry_o(accel_entry_o), .cur_pos_o(cur_pos_o),
		.home_done_o(home_done_o));

	dog_index_model axis (.core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_run_i(cmd_run_o),
		.cmd_dir_i(cmd_dir_o), .cmd_speed_i(cmd_speed_o), .load_i(load),
		.load_pos_i(load_pos), .active_high_i(pol_hi), .dog_o(dog_i), .index_o(index_i),
		.pos_o(feedback_pos_i));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("ERROR at %0t: %s", $time, msg);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// The request is held until waitrequest is seen low at a rising edge.
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk_i);
		address_i   <= a;
		writedata_i <= d;
		write_i     <= wr;
		read_i      <= !wr;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (waitrequest_o !== 1'b0 && n < 50);
		rd = readdata_o;
		chk(n < 50, "bus answer missing");
		write_i <= 1'b0;
		read_i  <= 1'b0;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic regs_after_reset();
		bus(1'b0, home_return_pkg::OFS_SEARCH, 32'h0);
		chk(rd[15:0] === home_return_pkg::RST_SEARCH, "search reset value");
		bus(1'b0, home_return_pkg::OFS_CREEP, 32'h0);
		chk(rd[15:0] === home_return_pkg::RST_CREEP, "creep reset value");
		bus(1'b0, home_return_pkg::OFS_POLARITY, 32'h0);
		chk(rd[0] === home_return_pkg::RST_POLARITY, "polarity reset value");
		bus(1'b0, 6'h24, 32'h0);
		chk(rd === 32'h0000_0000, "unmapped read");
		bus(1'b1, home_return_pkg::OFS_SEARCH, {16'h0000, SEARCH});
		bus(1'b1, home_return_pkg::OFS_CREEP, {16'h0000, CREEP});
		bus(1'b1, home_return_pkg::OFS_SHIFT, 32'h0000_0005);
		bus(1'b1, home_return_pkg::OFS_AFTER_DOG, 32'h0000_0007);
		bus(1'b1, home_return_pkg::OFS_PRESET, PRESET);
		$display("test registers done");
	endtask

	task automatic refused_with_table_select();
		@(posedge core_clk_i);
		table_index_select_i <= 5'h01;
		op_mode_select_1_i   <= 1'b1;
		repeat (10) @(posedge core_clk_i);
		chk(cmd_run_o === 1'b0, "started with a table select on");
		op_mode_select_1_i   <= 1'b0;
		table_index_select_i <= 5'h00;
		$display("test refused start done");
	endtask

	task automatic run_home(input logic [3:0] t, input logic d, input logic pol, input int st,
			input int exp);
		int n;
		n = 0;
		@(posedge core_clk_i);
		load_pos <= 32'(st);
		load     <= 1'b1;
		pol_hi   <= pol;
		@(posedge core_clk_i);
		load <= 1'b0;
		bus(1'b1, home_return_pkg::OFS_TYPE_DIR, {27'h0, d, t});
		bus(1'b1, home_return_pkg::OFS_POLARITY, {31'h0, pol});
		@(posedge core_clk_i);
		op_mode_select_1_i <= 1'b1;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (cmd_run_o !== 1'b1 && n < 8);
		op_mode_select_1_i <= 1'b0;
		chk(cmd_run_o === 1'b1, "homing did not start");
		chk(home_done_o === 1'b0, "done flag not cleared at start");
		chk(cmd_dir_o === d, "start direction");
		chk(accel_entry_o === home_return_pkg::HOMING_ENTRY, "ramp entry");
		chk(cmd_speed_o === ((t == home_return_pkg::TYPE_DOGLESS_Z) ? CREEP : SEARCH),
			"start speed");
		if (t != home_return_pkg::TYPE_DOGLESS_Z) begin
			n = 0;
			do begin
				@(posedge core_clk_i);
				n++;
			end while (decel_o !== 1'b1 && n < 300);
			chk(cmd_speed_o === CREEP, "creep after dog");
		end
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (home_done_o !== 1'b1 && n < 400);
		chk(home_done_o === 1'b1, "homing never completed");
		chk(cur_pos_o === PRESET, "preset not loaded");
		chk(cmd_run_o === 1'b0 && cmd_speed_o === 16'h0000, "motion not stopped");
		chk(accel_entry_o === home_return_pkg::NO_ENTRY, "ramp entry not released");
		n = int'(feedback_pos_i) - exp;
		chk(n >= -3 && n <= 3, "home reference position");
		$display("test type %0d dir %0d pol %0d done", t, d, pol);
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (5) @(posedge core_clk_i);
		rst_i <= 1'b0;
		regs_after_reset();
		refused_with_table_select();
		run_home(home_return_pkg::TYPE_DOG, 1'b0, 1'b1, 2, 69);
		bus(1'b0, home_return_pkg::OFS_STATUS, 32'h0);
		chk(rd[home_return_pkg::ST_DONE_BIT] === 1'b1, "status done bit");
		run_home(home_return_pkg::TYPE_REAR_END, 1'b0, 1'b1, 2, 72);
		run_home(home_return_pkg::TYPE_COUNT_FE, 1'b0, 1'b1, 2, 52);
		run_home(home_return_pkg::TYPE_CRADLE, 1'b0, 1'b1, 2, 48);
		run_home(home_return_pkg::TYPE_LAST_Z, 1'b0, 1'b1, 2, 27);
		run_home(home_return_pkg::TYPE_DOG_FE, 1'b0, 1'b1, 2, 52);
		run_home(home_return_pkg::TYPE_DOGLESS_Z, 1'b0, 1'b1, 2, 21);
		run_home(home_return_pkg::TYPE_DOG, 1'b1, 1'b1, 100, 27);
		run_home(home_return_pkg::TYPE_CRADLE, 1'b0, 1'b0, 2, 48);
		summarize();
	end

	// A full run takes well under 10,000 cycles; this cuts a hang short.
	initial begin
		#200000;
		n_mismatch++;
		$display("ERROR at %0t: watchdog expired", $time);
		summarize();
	end
endmodule
